// ==== verilog/tes_event_select_regs.sv ====
// trace event selector, event behaviour and data compare value register bank
// assumes one Avalon-MM master on core_clk, and resource logic that turns the
// selector fields into per-event hits
module tes_event_select_regs #(
   parameter int NUM_DVC = 8,
   parameter int DV_WIDTH = 64,
   parameter logic [1:0] EVENT_COUNT_ID = 2'h3,
   parameter logic [3:0] RSPAIR_COUNT_ID = 4'h1,
   parameter int ARCH_MINOR = 3,
   parameter bit DATA_TRACE = 1'b1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input tes_pkg::tes_avs_req_type avs_req,
   output tes_pkg::tes_avs_rsp_type avs_rsp,
   input wire logic trace_enable,
   input wire logic trace_idle,
   input wire logic [tes_pkg::NUM_EVENTS-1:0] event_hit,
   output logic [31:0] event_select,
   output logic [tes_pkg::EBEH_W-1:0] event_behavior,
   output logic [tes_pkg::NUM_EVENTS-1:0] instr_event,
   output logic data_event
);

   // ==========================================================================
   // configuration checks
   // the index decode serves at most the region's eight compare value pairs
   if (NUM_DVC < 1 || NUM_DVC > tes_pkg::MAX_DVC) begin : g_bad_num_dvc
      $error("NUM_DVC out of range");
   end

   // the compare value never holds more than its 64 field bits
   if (DV_WIDTH < 1 || DV_WIDTH > tes_pkg::DVC_W) begin : g_bad_dv_width
      $error("DV_WIDTH out of range");
   end

   // the revision number must fit its identification byte
   if (ARCH_MINOR < 0 || ARCH_MINOR > 255) begin : g_bad_arch_minor
      $error("ARCH_MINOR out of range");
   end

   // ==========================================================================
   // derived configuration
   // from revision 4.3 a unit without resource pairs has no events at all
   localparam bit EVENTS_PRESENT = (ARCH_MINOR < 3) || (RSPAIR_COUNT_ID != 4'h0);
   localparam bit EV1_PRESENT = EVENTS_PRESENT && (EVENT_COUNT_ID != 2'h0);
   localparam bit EV2_PRESENT = EVENTS_PRESENT && EVENT_COUNT_ID[1];
   localparam bit EV3_PRESENT = EVENTS_PRESENT && (EVENT_COUNT_ID == 2'h3);
   localparam bit DATA_EVENT_ENABLE_PRESENT = DATA_TRACE && EVENTS_PRESENT;

   // selector bytes of missing events stay zero
   localparam logic [31:0] ESEL_MASK = {
      {tes_pkg::ESEL_FIELD_W{EV3_PRESENT}},
      {tes_pkg::ESEL_FIELD_W{EV2_PRESENT}},
      {tes_pkg::ESEL_FIELD_W{EV1_PRESENT}},
      {tes_pkg::ESEL_FIELD_W{EVENTS_PRESENT}}
   };

   localparam logic [tes_pkg::NUM_EVENTS-1:0] INSTR_EVENT_ENABLE_MASK = {
      EV3_PRESENT,
      EV2_PRESENT,
      EV1_PRESENT,
      EVENTS_PRESENT
   };

   // compare value bits above the implemented width read zero
   localparam logic [tes_pkg::DVC_W-1:0] DVC_MASK = (DV_WIDTH >= tes_pkg::DVC_W) ?
      {tes_pkg::DVC_W{1'b1}} : ((64'h1 << DV_WIDTH) - 64'h1);

   localparam int DVC_IDX_W = $clog2(tes_pkg::MAX_DVC);

   // ==========================================================================
   // constant words
   function automatic logic [tes_pkg::EBEH_W-1:0] ebeh_mask_f();
      logic [tes_pkg::EBEH_W-1:0] m;
      m = '0;
      m[tes_pkg::EBEH_INSTR_EVENT_ENABLE_LSB +: tes_pkg::NUM_EVENTS] = INSTR_EVENT_ENABLE_MASK;
      m[tes_pkg::EBEH_DATA_EVENT_ENABLE_BIT] = DATA_EVENT_ENABLE_PRESENT;
      return m;
   endfunction : ebeh_mask_f

   function automatic logic [tes_pkg::DATA_W-1:0] ident_f();
      logic [tes_pkg::DATA_W-1:0] w;
      w = '0;
      w[tes_pkg::ID_EVCNT_LSB +: 2] = EVENT_COUNT_ID;
      w[tes_pkg::ID_RSPAIR_LSB +: 4] = RSPAIR_COUNT_ID;
      w[tes_pkg::ID_DATA_BIT] = DATA_TRACE;
      w[tes_pkg::ID_DVW_LSB +: 8] = 8'(DV_WIDTH);
      w[tes_pkg::ID_MINOR_LSB +: 8] = 8'(ARCH_MINOR);
      return w;
   endfunction : ident_f

   localparam logic [tes_pkg::EBEH_W-1:0] EBEH_MASK = ebeh_mask_f();
   localparam logic [tes_pkg::DATA_W-1:0] IDENT_WORD = ident_f();

   // ==========================================================================
   // state
   // compare values live in flip-flops, one 64-bit word per comparator
   typedef struct packed {
      logic [31:0] esel;
      logic [tes_pkg::EBEH_W-1:0] ebeh;
      logic [NUM_DVC-1:0][tes_pkg::DVC_W-1:0] dvc;
      logic drop;
      logic waitreq;
      logic [tes_pkg::DATA_W-1:0] rdata;
   } tes_esr_state_type;

   tes_esr_state_type s_reg;
   tes_esr_state_type s_next;

   // ==========================================================================
   // request decode
   logic req_live;
   logic req_first;
   logic req_commit;
   logic regs_free;
   logic hit_esel;
   logic hit_ebeh;
   logic hit_status;
   logic hit_ident;
   logic hit_dvc;
   logic hit_gated;
   logic [DVC_IDX_W-1:0] dvc_idx;
   logic dvc_high;
   logic [tes_pkg::DATA_W-1:0] rd_word;

   assign req_live = avs_req.read | avs_req.write;

   // first cycle of a request: waitrequest still high, read data loaded
   assign req_first = req_live & s_reg.waitreq;

   // second cycle: waitrequest low, the write lands here
   assign req_commit = req_live & ~s_reg.waitreq;

   // programming only while the unit is stopped and idle
   assign regs_free = ~trace_enable & trace_idle;

   // an absent selector register decodes as a hole
   assign hit_esel = EVENTS_PRESENT && (avs_req.address == tes_pkg::OFF_ESEL);
   assign hit_ebeh = avs_req.address == tes_pkg::OFF_EBEH;
   assign hit_status = avs_req.address == tes_pkg::OFF_STATUS;
   assign hit_ident = avs_req.address == tes_pkg::OFF_IDENT;

   // low word at even, high word at odd address of the region
   assign dvc_idx = avs_req.address[DVC_IDX_W:1];
   assign dvc_high = avs_req.address[0];
   assign hit_dvc = (avs_req.address[tes_pkg::ADDR_W-1 -: 2] == tes_pkg::OFF_DVC_REGION) &&
      (32'(dvc_idx) < NUM_DVC);

   assign hit_gated = hit_esel | hit_ebeh | hit_dvc;

   // ==========================================================================
   // read data
   always_comb begin
      rd_word = '0;
      if (hit_esel) begin
         rd_word = s_reg.esel;
      end else if (hit_ebeh) begin
         rd_word[tes_pkg::EBEH_W-1:0] = s_reg.ebeh;
      end else if (hit_status) begin
         rd_word[tes_pkg::STAT_DROP_BIT] = s_reg.drop;
         rd_word[tes_pkg::STAT_ENABLE_BIT] = trace_enable;
         rd_word[tes_pkg::STAT_IDLE_BIT] = trace_idle;
      end else if (hit_ident) begin
         rd_word = IDENT_WORD;
      end else if (hit_dvc) begin
         if (dvc_high) begin
            rd_word = s_reg.dvc[dvc_idx][tes_pkg::DVC_W-1 -: tes_pkg::DATA_W];
         end else begin
            rd_word = s_reg.dvc[dvc_idx][tes_pkg::DATA_W-1:0];
         end
      end
   end

   // ==========================================================================
   // next state
   // byte enables are not honoured: every register is written whole
   always_comb begin
      s_next = s_reg;

      // one wait state on every access keeps read data a plain flop
      if (req_first) begin
         s_next.waitreq = 1'b0;
         if (avs_req.read) begin
            s_next.rdata = rd_word;
         end
      end else begin
         s_next.waitreq = 1'b1;
      end

      if (req_commit && avs_req.write) begin
         // write one to clear the drop flag
         if (hit_status && avs_req.writedata[tes_pkg::STAT_DROP_BIT]) begin
            s_next.drop = 1'b0;
         end

         if (regs_free) begin
            if (hit_esel) begin
               s_next.esel = avs_req.writedata & ESEL_MASK;
            end
            if (hit_ebeh) begin
               s_next.ebeh = avs_req.writedata[tes_pkg::EBEH_W-1:0] & EBEH_MASK;
            end
            if (hit_dvc) begin
               if (dvc_high) begin
                  s_next.dvc[dvc_idx][tes_pkg::DVC_W-1 -: tes_pkg::DATA_W] =
                     avs_req.writedata & DVC_MASK[tes_pkg::DVC_W-1 -: tes_pkg::DATA_W];
               end else begin
                  s_next.dvc[dvc_idx][tes_pkg::DATA_W-1:0] =
                     avs_req.writedata & DVC_MASK[tes_pkg::DATA_W-1:0];
               end
            end
         end else if (hit_gated) begin
            // set after clear, so a new drop always wins
            s_next.drop = 1'b1;
         end
      end
   end

   // ==========================================================================
   // registers
   // reset content is architecturally unknown; zero is simply a safe choice
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg.esel <= tes_pkg::ESEL_RST;
         s_reg.ebeh <= tes_pkg::EBEH_RST;
         s_reg.dvc <= {NUM_DVC{tes_pkg::DVC_RST}};
         s_reg.drop <= 1'b0;
         s_reg.waitreq <= 1'b1;
         s_reg.rdata <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================================
   // bus and field outputs
   assign avs_rsp.readdata = s_reg.rdata;
   assign avs_rsp.waitrequest = s_reg.waitreq;
   assign event_select = s_reg.esel;
   assign event_behavior = s_reg.ebeh;

   // ==========================================================================
   // event gating
   // only event 0 has a data stream enable, the others feed instructions only
   for (genvar g = 0; g < tes_pkg::NUM_EVENTS; g++) begin : g_gate
      if (g == 0) begin : g_with_data
         tes_event_gate i_tes_event_gate (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .event_hit(event_hit[g]),
            .instr_enable(s_reg.ebeh[tes_pkg::EBEH_INSTR_EVENT_ENABLE_LSB + g]),
            .data_enable(s_reg.ebeh[tes_pkg::EBEH_DATA_EVENT_ENABLE_BIT]),
            .instr_event(instr_event[g]),
            .data_event(data_event)
         );
      end else begin : g_instr_only
         tes_event_gate i_tes_event_gate (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .event_hit(event_hit[g]),
            .instr_enable(s_reg.ebeh[tes_pkg::EBEH_INSTR_EVENT_ENABLE_LSB + g]),
            .data_enable(1'b0),
            .instr_event(instr_event[g]),
            .data_event()
         );
      end
   end

endmodule : tes_event_select_regs

// ==== verilog/tes_pkg.sv ====
// shared constants and carrier types of the trace event select register bank
// assumes an Avalon-MM master with 32-bit data addressing whole words
package tes_pkg;

   // ==========================================================================
   // bus shape
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;

   // ==========================================================================
   // word offsets
   localparam logic [ADDR_W-1:0] OFF_ESEL = 6'h00;
   localparam logic [ADDR_W-1:0] OFF_EBEH = 6'h01;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h02;
   localparam logic [ADDR_W-1:0] OFF_IDENT = 6'h03;
   // compare values: low word at base + 2n, high word at base + 2n + 1
   localparam logic [1:0] OFF_DVC_REGION = 2'h1;
   localparam int MAX_DVC = 8;

   // ==========================================================================
   // event selector control fields
   localparam int NUM_EVENTS = 4;
   localparam int ESEL_FIELD_W = 8;
   localparam logic [31:0] ESEL_RST = 32'h0000_0000;

   // ==========================================================================
   // event behaviour control fields
   localparam int EBEH_W = 5;
   localparam int EBEH_INSTR_EVENT_ENABLE_LSB = 0;
   localparam int EBEH_DATA_EVENT_ENABLE_BIT = 4;
   localparam logic [EBEH_W-1:0] EBEH_RST = 5'h00;

   // ==========================================================================
   // status fields
   localparam int STAT_DROP_BIT = 0;
   localparam int STAT_ENABLE_BIT = 1;
   localparam int STAT_IDLE_BIT = 2;

   // ==========================================================================
   // identification fields
   localparam int ID_EVCNT_LSB = 0;
   localparam int ID_RSPAIR_LSB = 4;
   localparam int ID_DATA_BIT = 8;
   localparam int ID_DVW_LSB = 16;
   localparam int ID_MINOR_LSB = 24;

   // ==========================================================================
   // compare value
   localparam int DVC_W = 64;
   localparam logic [63:0] DVC_RST = 64'h0000_0000_0000_0000;

   // ==========================================================================
   // carriers
   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
      logic [BE_W-1:0] byteenable;
   } tes_avs_req_type;

   typedef struct packed {
      logic [DATA_W-1:0] readdata;
      logic waitrequest;
   } tes_avs_rsp_type;

endpackage : tes_pkg

// ==== verilog/tes_event_gate.sv ====
// one event's gating towards the instruction and data trace streams
// assumes the hit input is already the selected resource outcome, one clock
module tes_event_gate (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic event_hit,
   input wire logic instr_enable,
   input wire logic data_enable,
   output logic instr_event,
   output logic data_event
);

   // ==========================================================================
   // state
   typedef struct packed {
      logic instr;
      logic data;
   } tes_gate_state_type;

   tes_gate_state_type s_reg;
   tes_gate_state_type s_next;

   always_comb begin
      s_next = s_reg;
      s_next.instr = event_hit & instr_enable;
      s_next.data = event_hit & data_enable;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign instr_event = s_reg.instr;
   assign data_event = s_reg.data;

endmodule : tes_event_gate

// ==== verification/tes_esr_assertions.sv ====
// port assertions of the event select register bank
// assumes a bind into tes_event_select_regs, whole-word writes
module tes_esr_assertions #(
   parameter logic [1:0] EVENT_COUNT_ID = 2'h3
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input tes_pkg::tes_avs_req_type avs_req,
   input tes_pkg::tes_avs_rsp_type avs_rsp,
   input wire logic trace_enable,
   input wire logic trace_idle,
   input wire logic [31:0] event_select,
   input wire logic [4:0] event_behavior
);
   // ==========================================================
   // helpers
   localparam logic [31:0] EM = {{8{EVENT_COUNT_ID == 2'h3}}, {8{EVENT_COUNT_ID[1]}}, {8{|EVENT_COUNT_ID}}, 8'hFF};
   localparam logic [4:0] BM = {1'b1, EM[24], EM[16], EM[8], 1'b1};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire logic acc = avs_req.write && !avs_rsp.waitrequest;
   wire logic free_w = !trace_enable && trace_idle;
   wire logic to_esel = avs_req.address == tes_pkg::OFF_ESEL;
   wire logic to_ebeh = avs_req.address == tes_pkg::OFF_EBEH;
   a_esel_unimpl_zero: assert property ((event_select & ~EM) == 32'h0) else $error("selector spare bits set");
   a_behav_unimpl_zero: assert property ((event_behavior & ~BM) == 5'h00) else $error("enable spare bits set");
   a_esel_write_lands: assert property (acc && to_esel && free_w |=> event_select == ($past(avs_req.writedata) & EM))
      else $error("selector write lost");
   a_behav_write_lands: assert property (acc && to_ebeh && free_w |=> event_behavior == ($past(avs_req.writedata[4:0]) & BM))
      else $error("enable write lost");
   a_busy_write_drop: assert property (acc && !free_w |=> $stable(event_select) && $stable(event_behavior))
      else $error("write taken while busy");
   a_quiet_hold: assert property (!acc |=> $stable(event_select)) else $error("selector moved alone");
   a_read_esel: assert property (avs_req.read && !avs_rsp.waitrequest && to_esel |-> avs_rsp.readdata == event_select)
      else $error("selector read wrong");
   a_wait_bounded: assert property (avs_req.read || avs_req.write |-> ##[0:32] !avs_rsp.waitrequest)
      else $error("no answer");
   c_esel_write: cover property (acc && to_esel && free_w);
   c_busy_write: cover property (acc && !free_w);
   c_read: cover property (avs_req.read && !avs_rsp.waitrequest);
endmodule : tes_esr_assertions
bind tes_event_select_regs tes_esr_assertions #(.EVENT_COUNT_ID(EVENT_COUNT_ID)) i_tes_esr_assertions (.core_clk(core_clk),
   .rst_n(rst_n), .avs_req(avs_req), .avs_rsp(avs_rsp), .trace_enable(trace_enable), .trace_idle(trace_idle),
   .event_select(event_select), .event_behavior(event_behavior));

// ==== verification/tes_event_select_regs_tb.sv ====
// register bench of the event select register bank
// assumes an Avalon-MM slave on core_clk; narrow build to reach spare bits
module tes_event_select_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // stimulus
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic trace_enable = 1'b0;
   logic trace_idle = 1'b1;
   logic [3:0] event_hit = 4'h0;
   logic [31:0] q;
   tes_pkg::tes_avs_req_type avs_req = '0;
   tes_pkg::tes_avs_rsp_type avs_rsp;
   logic [31:0] event_select;
   logic [4:0] event_behavior;
   logic [3:0] instr_event;
   logic data_event;
   int n_errors = 0;
   int num_checks = 0;
   always #2.5 core_clk = ~core_clk;
   tes_event_select_regs #(.DV_WIDTH(32), .EVENT_COUNT_ID(2'h1)) i_tes_event_select_regs (.core_clk(core_clk),
      .rst_n(rst_n), .avs_req(avs_req), .avs_rsp(avs_rsp), .trace_enable(trace_enable), .trace_idle(trace_idle),
      .event_hit(event_hit), .event_select(event_select), .event_behavior(event_behavior),
      .instr_event(instr_event), .data_event(data_event));
   task automatic results();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   // one transfer, held until waitrequest is seen low
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int i;
      avs_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (avs_rsp.waitrequest !== 1'b0 && i < 50);
      if (i >= 50) begin
         n_errors++;
         results();
      end
      q = avs_rsp.readdata;
      avs_req <= '0;
      @(posedge core_clk);
   endtask : xfer
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, s);
         n_errors++;
      end
   endtask : chk
   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      event_hit <= 4'h5;
      @(posedge core_clk);
      xfer(1'b1, tes_pkg::OFF_ESEL, 32'hC3A55A3C);
      xfer(1'b0, tes_pkg::OFF_ESEL, 32'h0);
      chk("esel", 32'h00005A3C, q);
      chk("esel port", 32'h00005A3C, event_select);
      xfer(1'b1, tes_pkg::OFF_EBEH, 32'hFFFFFFFF);
      chk("ebeh port", 32'h13, {27'h0, event_behavior});
      @(posedge core_clk);
      chk("instr event", 32'h1, {28'h0, instr_event});
      chk("data event", 32'h1, {31'h0, data_event});
      xfer(1'b1, 6'h10, 32'h89ABCDEF);
      xfer(1'b1, 6'h11, 32'h89ABCDEF);
      xfer(1'b0, 6'h10, 32'h0);
      chk("dvc low", 32'h89ABCDEF, q);
      xfer(1'b0, 6'h11, 32'h0);
      chk("dvc high", 32'h0, q);
      trace_enable <= 1'b1;
      xfer(1'b1, tes_pkg::OFF_ESEL, 32'h0);
      trace_enable <= 1'b0;
      trace_idle <= 1'b0;
      xfer(1'b1, tes_pkg::OFF_ESEL, 32'h0);
      trace_idle <= 1'b1;
      xfer(1'b1, 6'h3F, 32'h0);
      xfer(1'b0, tes_pkg::OFF_ESEL, 32'h0);
      chk("esel kept", 32'h00005A3C, q);
      results();
   end
endmodule : tes_event_select_regs_tb
